// ==== logic/pdi_pkg.sv ====
// Purpose: Shared constants and types for the parallel digital input channel pair
// Assumes: Word and qualifier widths fixed by the pod pinout
// Notes:   Numbers named once here and used by name
package pdi_pkg;
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned SAMPLE_W    = 13;
  localparam int unsigned QUAL_W      = 8;
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned UPPER_LSB   = 3;
  localparam int unsigned RND_BIT     = 2;
  localparam int unsigned SAMPLE_TOUT_CYC = 4096;
  localparam logic [15:0] OFFSET_ZERO = 16'h8000;

  // Per channel configuration
  typedef struct packed {
    logic             digital;
    logic             src_alt;
    logic             size16;
    logic             bus16;
    logic             align_upper;
    logic             offset_bin;
    logic             edge_fall;
    logic             auto_range;
    logic [QUAL_W-1:0] qual_mask;
    logic [QUAL_W-1:0] qual_val;
  } pdi_cfg_type;

  // Per channel output sample
  typedef struct packed {
    logic                valid;
    logic [SAMPLE_W-1:0] data;
    logic                upper;
  } pdi_smp_type;
endpackage : pdi_pkg

// ==== logic/pdi_channel_pair.sv ====
// Purpose: Two digital input channels: source select, byte assembly, field select, format decode
// Assumes: Pod pins and clocks are asynchronous and pass two flops
// Notes:   Overview of rules listed below
// Overview of operation
// - Channel 1 digital takes words from internal source or pod 1.
// - Channel 2 digital takes words from pod 1 or pod 2.
// - Each channel accepts 8 or 16 bit data over an 8 or 16 bit bus.
// - For 16-bit data keep upper or lower 13-bit field as sample.
// - Upper field rounds using the three discarded least significant bits.
// - Lower field drops the three most significant bits without rounding.
// - Swept-sine auto range switches fields on its own for 16-bit range.
// - 8-bit bus takes one byte per sample or two bytes per 16-bit sample.
// - 8-bit bus reads only upper byte lines of the pod.
// - Twos complement: sign bit 0 positive, 1 negative.
// - Offset binary: sign bit 1 positive, 0 negative.
// - Decode per channel format; offset 8000 zero, FFFF max, 7FFF minus one.
// - Sample_absent_indication flag while sample clock absent; clears once valid clock appears.
// - Latch pod data on rising or falling data clock edge as selected.
// - With qualifiers, latch only when qualifier lines match pattern; don't cares match.
`timescale 1ns/1ps
module pdi_channel_pair
  import pdi_pkg::*;
#(
  parameter int unsigned TOUT_CYC = SAMPLE_TOUT_CYC
) (
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  input  wire pdi_cfg_type        cfg1,
  input  wire pdi_cfg_type        cfg2,
  input  wire logic               swept_sine,
  input  wire logic [WORD_W-1:0]  src_word,
  input  wire logic               src_strobe,
  input  wire logic [WORD_W-1:0]  pod1_data,
  input  wire logic               pod1_clk,
  input  wire logic [WORD_W-1:0]  pod2_data,
  input  wire logic               pod2_clk,
  input  wire logic [QUAL_W-1:0]  qualifier_lines,
  input  wire logic               sample_clk,
  input  wire logic               sample_clk_valid_cfg,
  output pdi_smp_type             smp1,
  output pdi_smp_type             smp2,
  output logic                    sample_absent_indication
);
  // Watchdog counter is wide enough to hold the full timeout count
  // It parks at its ceiling so the flag stays up while the clock is gone
  localparam int unsigned CW = $clog2(TOUT_CYC + 1);
  localparam logic [CW-1:0] TOUT_MAX = CW'(TOUT_CYC);

  // Per channel working state
  // phase marks that the high byte of a byte pair is held
  // word_vld pulses one cycle after each accepted latch that completes a word, not after the first byte of a pair
  // upper records which field the next sample will use

  typedef struct packed {
    logic                   phase;
    logic [BYTE_W-1:0]      hi_byte;
    logic [WORD_W-1:0]      word;
    logic                   word_vld;
    logic                   upper;
  } pdi_ch_type;

  // Whole block state
  // Pod pins, data clocks, qualifiers and sample clock pass two flops
  // Only stage 1 of each chain is read by logic, stage 0 never
  // The _prev copies hold last cycle's stage 1 for edge detection
  typedef struct packed {
    logic [1:0][WORD_W-1:0] p1_s;
    logic [1:0][WORD_W-1:0] p2_s;
    logic [1:0]             c1_s;
    logic [1:0]             c2_s;
    logic [1:0][QUAL_W-1:0] q_s;
    logic [1:0]             sc_s;
    logic                   c1_prev;
    logic                   c2_prev;
    logic                   sc_prev;
    pdi_ch_type [1:0]       ch;
    pdi_smp_type [1:0]      smp;
    logic [CW-1:0]          tout;
    logic                   absent;
  } pdi_state_type;

  pdi_state_type st_q, st_d;

  // Sample word conversion for one channel
  // Offset binary is turned into twos complement first by flipping the sign bit
  // 8-bit data sits in the top byte and is sign extended to the sample width
  // Upper field adds half an output step before dropping three bits
  // Rounding can carry past positive full scale, so that case saturates
  // Lower field keeps the low bits; large words wrap, which the user must avoid
  function automatic logic [SAMPLE_W:0] conv(input pdi_cfg_type c, input logic [WORD_W-1:0] w,
                                             input logic up);
    logic [WORD_W-1:0]   t;
    logic [WORD_W:0]     r;
    logic [SAMPLE_W-1:0] s;
    t = w;
    s = '0;
    r = '0;
    if (c.offset_bin) begin
      t[WORD_W-1] = ~w[WORD_W-1];
    end
    if (!c.size16) begin
      s = SAMPLE_W'({{(SAMPLE_W-BYTE_W){t[WORD_W-1]}}, t[WORD_W-1 -: BYTE_W]});
    end else if (up) begin
      r = {t[WORD_W-1], t} + (WORD_W+1)'({t[RND_BIT], {RND_BIT{1'b0}}});
      // Saturate when rounding overflows positive full scale
      if (r[WORD_W] != r[WORD_W-1]) begin
        s = {1'b0, {(SAMPLE_W-1){1'b1}}};
      end else begin
        s = r[WORD_W-1 -: SAMPLE_W];
      end
    end else begin
      s = t[SAMPLE_W-1:0];
    end
    return {up, s};
  endfunction : conv

  // Next state of both channels
  always_comb begin
    pdi_cfg_type       c;
    logic [1:0]        edge_hit;
    logic [WORD_W-1:0] w;
    logic              lat;
    logic [SAMPLE_W:0] cv;
    logic              big;
    c = '0;
    edge_hit = '0;
    w = '0;
    lat = 1'b0;
    cv = '0;
    big = 1'b0;
    st_d = st_q;
    st_d.p1_s = {st_q.p1_s[0], pod1_data};
    st_d.p2_s = {st_q.p2_s[0], pod2_data};
    st_d.c1_s = {st_q.c1_s[0], pod1_clk};
    st_d.c2_s = {st_q.c2_s[0], pod2_clk};
    st_d.q_s  = {st_q.q_s[0], qualifier_lines};
    st_d.sc_s = {st_q.sc_s[0], sample_clk};
    st_d.c1_prev = st_q.c1_s[1];
    st_d.c2_prev = st_q.c2_s[1];
    st_d.sc_prev = st_q.sc_s[1];
    for (int i = 0; i < 2; i++) begin
      c = (i == 0) ? cfg1 : cfg2;
      st_d.ch[i].word_vld = 1'b0;
      st_d.smp[i].valid = 1'b0;
      // Data clock edge of selected pod, with polarity choice
      edge_hit[0] = c.edge_fall ? (st_q.c1_prev & ~st_q.c1_s[1]) : (~st_q.c1_prev & st_q.c1_s[1]);
      edge_hit[1] = c.edge_fall ? (st_q.c2_prev & ~st_q.c2_s[1]) : (~st_q.c2_prev & st_q.c2_s[1]);
      if (i == 0) begin
        w   = c.src_alt ? src_word : st_q.p1_s[1];
        lat = c.src_alt ? src_strobe : edge_hit[0];
      end else begin
        w   = c.src_alt ? st_q.p2_s[1] : st_q.p1_s[1];
        lat = c.src_alt ? edge_hit[1] : edge_hit[0];
      end
      // Qualifier match, masked bits are don't care
      lat = lat & c.digital & (((st_q.q_s[1] ^ c.qual_val) & c.qual_mask) == '0);
      if (lat) begin
        if (c.bus16) begin
          st_d.ch[i].word = w;
          st_d.ch[i].word_vld = 1'b1;
        end else if (!c.size16) begin
          st_d.ch[i].word = {w[WORD_W-1 -: BYTE_W], {BYTE_W{1'b0}}};
          st_d.ch[i].word_vld = 1'b1;
        end else if (!st_q.ch[i].phase) begin
          st_d.ch[i].hi_byte = w[WORD_W-1 -: BYTE_W];
          st_d.ch[i].phase = 1'b1;
        end else begin
          st_d.ch[i].word = {st_q.ch[i].hi_byte, w[WORD_W-1 -: BYTE_W]};
          st_d.ch[i].word_vld = 1'b1;
          st_d.ch[i].phase = 1'b0;
        end
      end
      // Byte pairing restarts whenever the channel leaves the 8-bit bus, 16-bit data mode
      // Without this a stale high byte could pair with a byte of a later setup
      if (!c.digital || c.bus16 || !c.size16) begin
        st_d.ch[i].phase = 1'b0;
      end
      // Auto range picks the upper field when the stored word, not yet offset decoded, would overflow the lower one
      big = (st_q.ch[i].word[WORD_W-1:SAMPLE_W-1] != '0) && (st_q.ch[i].word[WORD_W-1:SAMPLE_W-1] != '1);
      if (st_q.ch[i].word_vld) begin
        st_d.ch[i].upper = (c.auto_range && swept_sine) ? big : c.align_upper;
      end
      // Sample on sample clock rising edge
      if (~st_q.sc_prev & st_q.sc_s[1] & c.digital) begin
        // The last latched word is sampled again if no new word arrived
        cv = conv(c, st_q.ch[i].word, st_q.ch[i].upper);
        st_d.smp[i].valid = 1'b1;
        st_d.smp[i].upper = cv[SAMPLE_W];
        st_d.smp[i].data  = cv[SAMPLE_W-1:0];
      end
    end
    // Sample_absent_indication watchdog on the external sample clock
    if (st_q.sc_prev != st_q.sc_s[1]) begin
      st_d.tout = '0;
    end else if (st_q.tout != TOUT_MAX) begin
      st_d.tout = st_q.tout + CW'(1);
    end
    st_d.absent = (st_q.tout == TOUT_MAX) || !sample_clk_valid_cfg;
  end

  // State register
  // Reset clears the sync chains as well, matching idle low pins, so no false edge follows
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs come straight from registers
  assign smp1 = st_q.smp[0];
  assign smp2 = st_q.smp[1];
  assign sample_absent_indication = st_q.absent;

  // Sample_absent_indication flag follows the configuration and the watchdog
  a_absent_cfg: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !sample_clk_valid_cfg |=> sample_absent_indication) else $error("absent flag not raised");

  a_absent_tout: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st_q.tout == TOUT_MAX) |=> sample_absent_indication) else $error("timeout not flagged");

  a_clear_valid: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (sample_clk_valid_cfg && st_q.tout == '0) |=> !sample_absent_indication) else $error("flag not cleared");

  // Any sample clock transition restarts the watchdog
  a_tout_restart: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st_q.sc_prev != st_q.sc_s[1]) |=> (st_q.tout == '0)) else $error("watchdog not restarted");

  // Samples come only from digital channels
  a_smp_digital1: assert property (@(posedge clk_sys) disable iff (sys_rst)
    smp1.valid |-> $past(cfg1.digital)) else $error("ch1 sample while analog");

  a_smp_digital2: assert property (@(posedge clk_sys) disable iff (sys_rst)
    smp2.valid |-> $past(cfg2.digital)) else $error("ch2 sample while analog");

  // Samples follow a rising edge of the synchronised sample clock
  a_smp_edge: assert property (@(posedge clk_sys) disable iff (sys_rst)
    smp2.valid |-> $past(st_q.sc_s[1]) && !$past(st_q.sc_prev)) else $error("sample without clock edge");

  a_smp_edge1: assert property (@(posedge clk_sys) disable iff (sys_rst)
    smp1.valid |-> $past(st_q.sc_s[1]) && !$past(st_q.sc_prev)) else $error("ch1 sample without clock edge");

  // A sample strobe lasts exactly one cycle
  a_smp_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
    smp1.valid |=> !smp1.valid) else $error("sample strobe too long");

  // Latches happen only when the qualifier pattern matches
  a_qual_gate1: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_q.ch[0].word_vld |-> $past(cfg1.digital && (((st_q.q_s[1] ^ cfg1.qual_val) & cfg1.qual_mask) == '0)))
    else $error("ch1 latch with qualifier mismatch");

  a_qual_gate2: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_q.ch[1].word_vld |-> $past(cfg2.digital && (((st_q.q_s[1] ^ cfg2.qual_val) & cfg2.qual_mask) == '0)))
    else $error("ch2 latch with qualifier mismatch");

  // Channel 1 internal source is taken on its strobe only
  a_src_path1: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st_q.ch[0].word_vld && $past(cfg1.src_alt))
    |-> $past(src_strobe) && (!$past(cfg1.bus16) || st_q.ch[0].word == $past(src_word)))
    else $error("ch1 source word wrong");

  // Channel 2 takes the selected pod's word
  a_pod_path2: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st_q.ch[1].word_vld && $past(cfg2.bus16))
    |-> st_q.ch[1].word == $past(cfg2.src_alt ? st_q.p2_s[1] : st_q.p1_s[1]))
    else $error("ch2 pod word wrong");

  // An 8-bit bus with 8-bit data leaves the low byte empty
  a_byte_lines: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st_q.ch[0].word_vld && $past(!cfg1.bus16 && !cfg1.size16)) |-> st_q.ch[0].word[BYTE_W-1:0] == '0)
    else $error("low byte lines used");

  a_byte_pair: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_q.ch[0].phase |-> $past(!cfg1.bus16 && cfg1.size16)) else $error("byte pairing outside 8/16 mode");

  // Lower field is the low bits of the word
  a_lower_trunc: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (smp1.valid && !smp1.upper && $past(cfg1.size16) && !$past(cfg1.offset_bin))
    |-> smp1.data == $past(st_q.ch[0].word[SAMPLE_W-1:0])) else $error("lower field wrong");

  // Upper field rounds half up away from the saturation corner
  a_upper_round: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (smp1.valid && smp1.upper && $past(cfg1.size16) && !$past(cfg1.offset_bin)
     && $past(st_q.ch[0].word[WORD_W-1:2]) != 14'h1FFF)
    |-> smp1.data == SAMPLE_W'(($past(st_q.ch[0].word) + 16'h0004) >> UPPER_LSB))
    else $error("upper field rounding wrong");

  a_upper_sat: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (smp1.valid && smp1.upper && $past(cfg1.size16) && !$past(cfg1.offset_bin)
     && $past(st_q.ch[0].word[WORD_W-1:2]) == 14'h1FFF)
    |-> smp1.data == 13'h0FFF) else $error("upper field not saturated");

  // 8-bit data is sign extended from the top byte
  a_byte_sign: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (smp1.valid && $past(!cfg1.size16 && !cfg1.offset_bin))
    |-> smp1.data == {{(SAMPLE_W-BYTE_W){$past(st_q.ch[0].word[WORD_W-1])}},
                      $past(st_q.ch[0].word[WORD_W-1 -: BYTE_W])})
    else $error("byte sample not sign extended");

  a_byte_offset: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (smp1.valid && $past(!cfg1.size16 && cfg1.offset_bin))
    |-> smp1.data == {{(SAMPLE_W-BYTE_W+1){~$past(st_q.ch[0].word[WORD_W-1])}},
                      $past(st_q.ch[0].word[WORD_W-2 -: BYTE_W-1])})
    else $error("offset byte not converted");

  // Field choice follows the fixed setting or the auto range decision
  a_fixed_align: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ($past(st_q.ch[1].word_vld) && !$past(cfg2.auto_range)) |-> st_q.ch[1].upper == $past(cfg2.align_upper))
    else $error("alignment not applied");

  a_auto_pick: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ($past(st_q.ch[0].word_vld) && $past(cfg1.auto_range && swept_sine))
    |-> st_q.ch[0].upper == ($past(st_q.ch[0].word[WORD_W-1:SAMPLE_W-1]) != 4'h0
                             && $past(st_q.ch[0].word[WORD_W-1:SAMPLE_W-1]) != 4'hF))
    else $error("auto range field wrong");
endmodule : pdi_channel_pair

// ==== sim/pdi_pod_model.sv ====
// Purpose: Far-side bus: pod word with data clock, plus sample clock
// Assumes: Data clock period 80 ns; clock stands still between words
// Notes:   Released data lines show the inverse of the last word
`timescale 1ns/1ps
module pdi_pod_model
  import pdi_pkg::*;
(
  input  wire logic         edge_fall,
  output logic [WORD_W-1:0] pod_data,
  output logic              pod_clk,
  output logic              sample_clk
);
  initial begin
    pod_data = '0;
    pod_clk = 1'b0;
    sample_clk = 1'b0;
  end
  // One word, held 40 ns each side of the active edge
  task send(input logic [WORD_W-1:0] w);
    pod_clk = edge_fall;
    pod_data = w;
    #40 pod_clk = ~edge_fall;
    #40 pod_clk = edge_fall;
    pod_data = ~w;
    #40;
  endtask : send
  // One sample clock period from the far side
  task tick;
    sample_clk = 1'b1;
    #40 sample_clk = 1'b0;
    #40;
  endtask : tick
endmodule : pdi_pod_model

// ==== sim/parallel_digital_input_channel_bench.sv ====
// Purpose: Self-checking bench for the digital input channel pair
// Assumes: Timeout of missed samples shortened to 64 cycles
// Notes:   Table rows cover format and field choice
`timescale 1ns/1ps
module parallel_digital_input_channel_bench;
  import pdi_pkg::*;
  typedef struct packed {logic up; logic ob; logic [15:0] w; logic [12:0] e;} pdi_row_type;
  logic clk_sys, sys_rst, swept_sine, src_strobe, valid_cfg, p1_clk, p2_clk, s_clk, absent;
  logic [WORD_W-1:0] src_word, p1_data, p2_data;
  logic [QUAL_W-1:0] qualifier_lines;
  pdi_cfg_type cfg1, cfg2;
  pdi_smp_type smp1, smp2, s1, s2;
  int num_errors = 0, num_checks = 0, v1 = 0, cyc = 0;
  pdi_row_type rows [9] = '{'{1'b0, 1'b0, 16'h0001, 13'h0001}, '{1'b0, 1'b0, 16'hFFFF, 13'h1FFF},
    '{1'b1, 1'b0, 16'h000C, 13'h0002}, '{1'b1, 1'b0, 16'h7FFF, 13'h0FFF}, '{1'b0, 1'b1, 16'h8000, 13'h0000},
    '{1'b0, 1'b1, 16'h7FFF, 13'h1FFF}, '{1'b1, 1'b1, 16'hFFFF, 13'h0FFF}, '{1'b1, 1'b1, 16'h0000, 13'h1000},
    '{1'b0, 1'b0, 16'hE005, 13'h0005}};
  pdi_channel_pair #(.TOUT_CYC(64)) u_pdi_channel_pair (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .cfg1(cfg1), .cfg2(cfg2), .swept_sine(swept_sine), .src_word(src_word), .src_strobe(src_strobe),
    .pod1_data(p1_data), .pod1_clk(p1_clk), .pod2_data(p2_data), .pod2_clk(p2_clk),
    .qualifier_lines(qualifier_lines), .sample_clk(s_clk), .sample_clk_valid_cfg(valid_cfg),
    .smp1(smp1), .smp2(smp2), .sample_absent_indication(absent));
  pdi_pod_model u_pdi_pod_model (.edge_fall(cfg1.edge_fall), .pod_data(p1_data), .pod_clk(p1_clk),
    .sample_clk(s_clk));
  pdi_pod_model u_pdi_pod_model_2 (.edge_fall(cfg2.edge_fall), .pod_data(p2_data), .pod_clk(p2_clk),
    .sample_clk());
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Catch one-cycle sample pulses
  always @(negedge clk_sys) begin
    if (smp1.valid === 1'b1) begin
      s1 = smp1;
      v1++;
    end
    if (smp2.valid === 1'b1) s2 = smp2;
  end
  // Cut a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  task chk13(input logic [12:0] g, input logic [12:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t data %h expected %h", $time, g, e);
    end
  endtask : chk13
  task chk1(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t flag %b expected %b", $time, g, e);
    end
  endtask : chk1
  // One pod word on channel 1, one sample, then compare
  task run1(input logic [15:0] w, input logic [12:0] e, input logic up);
    v1 = 0;
    u_pdi_pod_model.send(w);
    u_pdi_pod_model.tick();
    @(negedge clk_sys);
    chk1(v1 == 1, 1'b1);
    chk13(s1.data, e);
    chk1(s1.upper, up);
  endtask : run1
  task tally_and_finish;
    if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    {sys_rst, swept_sine, src_strobe, valid_cfg, cfg1, cfg2, src_word, qualifier_lines} = '0;
    sys_rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk13(smp1.data, 13'h0000);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk1(absent, 1'b1);
    valid_cfg = 1'b1;
    cfg1.digital = 1'b1;
    cfg1.size16 = 1'b1;
    cfg1.bus16 = 1'b1;
    foreach (rows[i]) begin
      cfg1.align_upper = rows[i].up;
      cfg1.offset_bin = rows[i].ob;
      @(negedge clk_sys);
      run1(rows[i].w, rows[i].e, rows[i].up);
    end
    chk1(absent, 1'b0);
    repeat (80) @(negedge clk_sys);
    chk1(absent, 1'b1);
    {cfg1.edge_fall, cfg1.align_upper, cfg1.offset_bin} = 3'b100;
    run1(16'h0123, 13'h0123, 1'b0);
    {cfg1.qual_mask, cfg1.qual_val, qualifier_lines} = {8'hFF, 8'hA5, 8'h5A};
    run1(16'h0456, 13'h0123, 1'b0);
    qualifier_lines = 8'hA5;
    run1(16'h0456, 13'h0456, 1'b0);
    {cfg1.qual_mask, qualifier_lines} = {8'h0F, 8'h55};
    run1(16'h0789, 13'h0789, 1'b0);
    {swept_sine, cfg1.auto_range} = 2'b11;
    run1(16'h4000, 13'h0800, 1'b1);
    run1(16'h0005, 13'h0005, 1'b0);
    {swept_sine, cfg1.auto_range, cfg1.bus16, cfg1.size16} = 4'h0;
    run1(16'h80C3, 13'h1F80, 1'b0);
    cfg1.size16 = 1'b1;
    u_pdi_pod_model.send(16'h12FF);
    run1(16'h3400, 13'h1234, 1'b0);
    {cfg1.src_alt, cfg1.bus16, src_word, src_strobe} = {2'b11, 16'h0ABC, 1'b1};
    @(negedge clk_sys);
    src_strobe = 1'b0;
    u_pdi_pod_model.tick();
    @(negedge clk_sys);
    chk13(s1.data, 13'h0ABC);
    cfg2 = '{digital: 1'b1, src_alt: 1'b1, size16: 1'b1, bus16: 1'b1, offset_bin: 1'b1, default: '0};
    u_pdi_pod_model_2.send(16'h8001);
    u_pdi_pod_model.tick();
    @(negedge clk_sys);
    chk13(s2.data, 13'h0001);
    chk13(s1.data, 13'h0ABC);
    // Channel 2 from pod 1, rising edge, channel 1 left on its source
    {cfg1.edge_fall, cfg2.src_alt} = 2'b00;
    u_pdi_pod_model.send(16'h8005);
    u_pdi_pod_model.tick();
    @(negedge clk_sys);
    chk13(s2.data, 13'h0005);
    chk13(s1.data, 13'h0ABC);
    tally_and_finish;
  end
endmodule : parallel_digital_input_channel_bench
